// *** logic/gated_timer_consts.vh ***
`ifndef GATED_TIMER_CONSTS_VH
`define GATED_TIMER_CONSTS_VH

// ==========================================================
// register map, register indices inside one timer slot (address bits 4:2)
`define REG_TIMER_CTRL     3'h0
`define REG_GATE_CTRL      3'h1
`define REG_COUNT_LOW      3'h2
`define REG_COUNT_HIGH     3'h3
`define REG_FLAGS          3'h4
`define REG_LAST           3'h4
`define ADDR_REG_LO        2
`define ADDR_REG_HI        4
`define ADDR_TMR_LO        5
`define ADDR_TMR_HI        6

// ==========================================================
// gate control fields
`define GC_ENABLE          7
`define GC_POL             6
`define GC_TOGGLE          5
`define GC_SPM             4
`define GC_ARMED           3
`define GC_LEVEL           2
`define GC_SS_HI           1
`define GC_SS_LO           0
`define GC_RESET           8'h00

// ==========================================================
// other fields
`define CTRL_ON            0
`define FLG_ROLL           0
`define FLG_GATE           1

// ==========================================================
// gate source codes
`define SS_PIN             2'h0
`define SS_T0_OVF          2'h1
`define SS_CMP1            2'h2
`define SS_CMP2            2'h3

// ==========================================================
// timing and misc
`define Q1_DIV_W           2
`define Q1_PHASE           2'h0
`define COUNT_MAX          16'hffff
`define COUNT_RESET        16'h0000
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// *** logic/gate_count_unit.v ***
`timescale 1ns/10ps
`include "gated_timer_consts.vh"

module gate_count_unit (
    input  wire        i_mclk,
    input  wire        i_rst_b,
    input  wire        i_q1,
    input  wire        i_count_tick,
    input  wire        i_timer_on,
    input  wire [7:0]  i_gate_ctrl,
    input  wire        i_armed,
    input  wire [3:0]  i_src,
    input  wire        i_wr_low,
    input  wire        i_wr_high,
    input  wire [7:0]  i_wdata,
    output wire [15:0] o_count,
    output wire        o_gate_level,
    output wire        o_done,
    output wire        o_gate_fall,
    output wire        o_rollover
);

// ==========================================================
// gate path
reg         sel_gate;
wire        pol_gate;
wire        tog_gate;
wire        eff_gate;
wire        tog_rise;
wire        tog_fall;
wire        pol_rise;
wire        inc;
reg         prev_pol_ff;
reg         prev_tog_ff;
reg         tff_ff;
reg         sp_act_ff;
reg         gval_ff;
reg         prev_gval_ff;
reg         gfall_ff;
reg         roll_ff;
reg  [15:0] count_ff;
reg  [15:0] nxt_count;

always @* begin
    case (i_gate_ctrl[`GC_SS_HI:`GC_SS_LO])
        `SS_PIN:    sel_gate = i_src[0];
        `SS_T0_OVF: sel_gate = i_src[1];
        `SS_CMP1:   sel_gate = i_src[2];
        `SS_CMP2:   sel_gate = i_src[3];
        default:    sel_gate = i_src[0];
    endcase
end

assign pol_gate = i_gate_ctrl[`GC_POL] ? sel_gate : ~sel_gate;
assign pol_rise = pol_gate & ~prev_pol_ff;
assign tog_gate = i_gate_ctrl[`GC_TOGGLE] ? tff_ff : pol_gate;
assign tog_rise = tog_gate & ~prev_tog_ff;
assign tog_fall = ~tog_gate & prev_tog_ff;
// single pulse sits after the toggle so one full period is caught
assign eff_gate = i_gate_ctrl[`GC_SPM] ? sp_act_ff : tog_gate;
assign o_done   = i_gate_ctrl[`GC_SPM] & sp_act_ff & tog_fall;

always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        prev_pol_ff <= 1'b0;
        prev_tog_ff <= 1'b0;
        tff_ff      <= 1'b0;
        sp_act_ff   <= 1'b0;
    end else begin
        prev_pol_ff <= pol_gate;
        prev_tog_ff <= tog_gate;
        if (!i_timer_on || !i_gate_ctrl[`GC_TOGGLE]) begin
            tff_ff <= 1'b0;
        end else if (pol_rise) begin
            tff_ff <= ~tff_ff;
        end
        if (!i_gate_ctrl[`GC_SPM]) begin
            sp_act_ff <= 1'b0;
        end else if (!sp_act_ff && i_armed && tog_rise) begin
            sp_act_ff <= 1'b1;
        end else if (sp_act_ff && tog_fall) begin
            sp_act_ff <= 1'b0;
        end
    end
end

// ==========================================================
// level status, latched once per instruction cycle
always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        gval_ff      <= 1'b0;
        prev_gval_ff <= 1'b0;
        gfall_ff     <= 1'b0;
    end else begin
        if (i_q1) begin
            gval_ff <= eff_gate;
        end
        prev_gval_ff <= gval_ff;
        gfall_ff     <= prev_gval_ff & ~gval_ff;
    end
end

// ==========================================================
// counter
assign inc = i_count_tick & i_timer_on &
             (~i_gate_ctrl[`GC_ENABLE] | gval_ff);

always @* begin
    nxt_count = count_ff;
    if (inc) begin
        nxt_count = count_ff + 16'h0001;
    end
    // a software write wins over a coincident increment in the byte it writes
    if (i_wr_low) begin
        nxt_count[7:0] = i_wdata;
    end
    if (i_wr_high) begin
        nxt_count[15:8] = i_wdata;
    end
end

always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        count_ff <= `COUNT_RESET;
        roll_ff  <= 1'b0;
    end else begin
        count_ff <= nxt_count;
        roll_ff  <= inc & (count_ff == `COUNT_MAX) & ~i_wr_low & ~i_wr_high;
    end
end

assign o_count      = count_ff;
assign o_gate_level = gval_ff;
assign o_gate_fall  = gfall_ff;
assign o_rollover   = roll_ff;

endmodule // gate_count_unit

// *** logic/gated_timer_top.v ***
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "gated_timer_consts.vh"

module gated_timer_top #(
    parameter ADDR_W = 8,
    parameter N_TMR  = 3
) (
    input  wire              i_mclk,
    input  wire              i_rst_b,
    input  wire [ADDR_W-1:0] i_s_axi_awaddr,
    input  wire              i_s_axi_awvalid,
    output wire              o_s_axi_awready,
    input  wire [31:0]       i_s_axi_wdata,
    input  wire [3:0]        i_s_axi_wstrb,
    input  wire              i_s_axi_wvalid,
    output wire              o_s_axi_wready,
    output wire [1:0]        o_s_axi_bresp,
    output wire              o_s_axi_bvalid,
    input  wire              i_s_axi_bready,
    input  wire [ADDR_W-1:0] i_s_axi_araddr,
    input  wire              i_s_axi_arvalid,
    output wire              o_s_axi_arready,
    output wire [31:0]       o_s_axi_rdata,
    output wire [1:0]        o_s_axi_rresp,
    output wire              o_s_axi_rvalid,
    input  wire              i_s_axi_rready,
    input  wire [N_TMR-1:0]  i_gate_pin,
    input  wire              i_cmp1_out,
    input  wire              i_cmp2_out,
    input  wire              i_timer0_ovf,
    input  wire [N_TMR-1:0]  i_count_tick,
    output wire [N_TMR-1:0]  o_rollover_flag,
    output wire [N_TMR-1:0]  o_gate_event_flag
);

// ==========================================================
// input synchronisers
localparam N_ASYNC = N_TMR + 2;

reg  [N_ASYNC-1:0]       sync1_ff;
reg  [N_ASYNC-1:0]       sync2_ff;
reg  [`Q1_DIV_W-1:0]     q1_div_ff;
wire                     q1;

always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        sync1_ff <= {N_ASYNC{1'b0}};
        sync2_ff <= {N_ASYNC{1'b0}};
    end else begin
        sync1_ff <= {i_cmp2_out, i_cmp1_out, i_gate_pin};
        sync2_ff <= sync1_ff;
    end
end

// ==========================================================
// instruction cycle divider, q1 is its first phase
always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        q1_div_ff <= `Q1_PHASE;
    end else begin
        q1_div_ff <= q1_div_ff + {{(`Q1_DIV_W-1){1'b0}}, 1'b1};
    end
end

assign q1 = (q1_div_ff == `Q1_PHASE);

// ==========================================================
// axi4-lite write channel
reg                      aw_held_ff;
reg  [ADDR_W-1:0]        awaddr_ff;
reg                      w_held_ff;
reg  [7:0]               wdata_ff;
reg                      wstrb0_ff;
reg                      bvalid_ff;
reg  [1:0]               bresp_ff;
wire                     do_write;
wire [1:0]               w_tmr;
wire [2:0]               w_reg;
wire                     w_ok;

assign o_s_axi_awready = ~aw_held_ff & ~bvalid_ff;
assign o_s_axi_wready  = ~w_held_ff & ~bvalid_ff;
assign do_write        = aw_held_ff & w_held_ff & ~bvalid_ff;
assign w_tmr           = awaddr_ff[`ADDR_TMR_HI:`ADDR_TMR_LO];
assign w_reg           = awaddr_ff[`ADDR_REG_HI:`ADDR_REG_LO];
// unmapped: upper address bits set, timer slot past the last, or hole
assign w_ok            = (awaddr_ff[ADDR_W-1:`ADDR_TMR_HI+1] == {(ADDR_W-`ADDR_TMR_HI-1){1'b0}}) &
                         ({30'h0, w_tmr} < N_TMR) & (w_reg <= `REG_LAST);

always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        aw_held_ff <= 1'b0;
        awaddr_ff  <= {ADDR_W{1'b0}};
        w_held_ff  <= 1'b0;
        wdata_ff   <= 8'h00;
        wstrb0_ff  <= 1'b0;
        bvalid_ff  <= 1'b0;
        bresp_ff   <= `RESP_OKAY;
    end else begin
        if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= i_s_axi_wdata[7:0];
            wstrb0_ff <= i_s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= w_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_ff && i_s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end
end

assign o_s_axi_bvalid = bvalid_ff;
assign o_s_axi_bresp  = bresp_ff;

// ==========================================================
// per-timer registers and gate/count units
wire [N_TMR*8-1:0]       ctrl_vec;
wire [N_TMR*8-1:0]       gate_vec;
wire [N_TMR*16-1:0]      count_vec;
wire [N_TMR*8-1:0]       flag_vec;

genvar g;
generate
    for (g = 0; g < N_TMR; g = g + 1) begin : tmr
        reg         on_ff;
        reg  [7:0]  gc_ff;
        reg         armed_ff;
        reg         roll_flg_ff;
        reg         gev_flg_ff;
        wire        sel;
        wire        wr_gc;
        wire        done;
        wire        gfall;
        wire        roll;
        wire        level;
        wire [15:0] cnt;
        wire [7:0]  gc_live;

        assign sel   = do_write & w_ok & wstrb0_ff & ({30'h0, w_tmr} == g);
        assign wr_gc = sel & (w_reg == `REG_GATE_CTRL);

        always @(posedge i_mclk) begin
            if (!i_rst_b) begin
                on_ff       <= 1'b0;
                gc_ff       <= `GC_RESET;
                armed_ff    <= 1'b0;
                roll_flg_ff <= 1'b0;
                gev_flg_ff  <= 1'b0;
            end else begin
                if (sel && (w_reg == `REG_TIMER_CTRL)) begin
                    on_ff <= wdata_ff[`CTRL_ON];
                end
                if (wr_gc) begin
                    gc_ff <= wdata_ff;
                end
                // a write from software takes precedence over the hardware clear
                if (wr_gc) begin
                    armed_ff <= wdata_ff[`GC_ARMED] & wdata_ff[`GC_SPM];
                end else if (done || !gc_ff[`GC_SPM]) begin
                    armed_ff <= 1'b0;
                end
                // a new event wins over a clear in the same cycle
                if (roll) begin
                    roll_flg_ff <= 1'b1;
                end else if (sel && (w_reg == `REG_FLAGS) && wdata_ff[`FLG_ROLL]) begin
                    roll_flg_ff <= 1'b0;
                end
                if (gfall) begin
                    gev_flg_ff <= 1'b1;
                end else if (sel && (w_reg == `REG_FLAGS) && wdata_ff[`FLG_GATE]) begin
                    gev_flg_ff <= 1'b0;
                end
            end
        end

        gate_count_unit u_unit (
            .i_mclk       (i_mclk),
            .i_rst_b      (i_rst_b),
            .i_q1         (q1),
            .i_count_tick (i_count_tick[g]),
            .i_timer_on   (on_ff),
            .i_gate_ctrl  (gc_ff),
            .i_armed      (armed_ff),
            .i_src        ({sync2_ff[N_TMR+1], sync2_ff[N_TMR], i_timer0_ovf, sync2_ff[g]}),
            .i_wr_low     (sel && (w_reg == `REG_COUNT_LOW)),
            .i_wr_high    (sel && (w_reg == `REG_COUNT_HIGH)),
            .i_wdata      (wdata_ff),
            .o_count      (cnt),
            .o_gate_level (level),
            .o_done       (done),
            .o_gate_fall  (gfall),
            .o_rollover   (roll)
        );

        assign gc_live = {gc_ff[7:4], armed_ff, level, gc_ff[1:0]};
        assign ctrl_vec[g*8 +: 8]   = {7'h00, on_ff};
        assign gate_vec[g*8 +: 8]   = gc_live;
        assign count_vec[g*16 +: 16] = cnt;
        assign flag_vec[g*8 +: 8]   = {6'h00, gev_flg_ff, roll_flg_ff};
        assign o_rollover_flag[g]   = roll_flg_ff;
        assign o_gate_event_flag[g] = gev_flg_ff;
    end
endgenerate

// ==========================================================
// axi4-lite read channel
reg                      rvalid_ff;
reg  [31:0]              rdata_ff;
reg  [1:0]               rresp_ff;
reg  [7:0]               rd_byte;
wire [1:0]               r_tmr;
wire [2:0]               r_reg;
wire                     r_ok;

assign r_tmr = i_s_axi_araddr[`ADDR_TMR_HI:`ADDR_TMR_LO];
assign r_reg = i_s_axi_araddr[`ADDR_REG_HI:`ADDR_REG_LO];
assign r_ok  = (i_s_axi_araddr[ADDR_W-1:`ADDR_TMR_HI+1] == {(ADDR_W-`ADDR_TMR_HI-1){1'b0}}) &
               ({30'h0, r_tmr} < N_TMR) & (r_reg <= `REG_LAST);

always @* begin
    rd_byte = 8'h00;
    if (r_ok) begin
        case (r_reg)
            `REG_TIMER_CTRL: rd_byte = ctrl_vec[r_tmr*8 +: 8];
            `REG_GATE_CTRL:  rd_byte = gate_vec[r_tmr*8 +: 8];
            `REG_COUNT_LOW:  rd_byte = count_vec[r_tmr*16 +: 8];
            `REG_COUNT_HIGH: rd_byte = count_vec[r_tmr*16+8 +: 8];
            `REG_FLAGS:      rd_byte = flag_vec[r_tmr*8 +: 8];
            default:         rd_byte = 8'h00;
        endcase
    end
end

assign o_s_axi_arready = ~rvalid_ff;

always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        rvalid_ff <= 1'b0;
        rdata_ff  <= 32'h0000_0000;
        rresp_ff  <= `RESP_OKAY;
    end else begin
        if (i_s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= {24'h00_0000, rd_byte};
            rresp_ff  <= r_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_ff && i_s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
end

assign o_s_axi_rvalid = rvalid_ff;
assign o_s_axi_rdata  = rdata_ff;
assign o_s_axi_rresp  = rresp_ff;

endmodule // gated_timer_top

// *** dv/gated_timer_sva.sv ***
`timescale 1ns/10ps
// ==========================================
// bus and flag checks
module gated_timer_sva #(
    parameter ADDR_W = 8,
    parameter N_TMR  = 3
) (
    input wire             i_mclk,
    input wire             i_rst_b,
    input wire             o_s_axi_awready,
    input wire             o_s_axi_wready,
    input wire [1:0]       o_s_axi_bresp,
    input wire             o_s_axi_bvalid,
    input wire             i_s_axi_bready,
    input wire             i_s_axi_arvalid,
    input wire             o_s_axi_arready,
    input wire [31:0]      o_s_axi_rdata,
    input wire [1:0]       o_s_axi_rresp,
    input wire             o_s_axi_rvalid,
    input wire             i_s_axi_rready,
    input wire [N_TMR-1:0] i_count_tick,
    input wire [N_TMR-1:0] o_rollover_flag,
    input wire [N_TMR-1:0] o_gate_event_flag
);
default clocking cb @(posedge i_mclk); endclocking
default disable iff (!i_rst_b);
property p_bhold;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
endproperty
a_bhold: assert property (p_bhold) else $error("write answer dropped early");
property p_rhold;
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
endproperty
a_rhold: assert property (p_rhold) else $error("read answer dropped early");
property p_rdlat;
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
endproperty
a_rdlat: assert property (p_rdlat) else $error("read answer late");
property p_rdhi;
    o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000;
endproperty
a_rdhi: assert property (p_rdhi) else $error("upper read lanes set");
property p_arr;
    o_s_axi_arready == !o_s_axi_rvalid;
endproperty
a_arr: assert property (p_arr) else $error("arready wrong");
property p_bbusy;
    o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready;
endproperty
a_bbusy: assert property (p_bbusy) else $error("write taken while answer pending");
// flag register adds one stage behind the wrap tick
property p_roll;
    $rose(o_rollover_flag[1]) |-> $past(i_count_tick[1], 2);
endproperty
a_roll: assert property (p_roll) else $error("rollover without tick");
property p_rstidle;
    $rose(i_rst_b) |-> o_rollover_flag == 0 && o_gate_event_flag == 0 && !o_s_axi_rvalid;
endproperty
a_rstidle: assert property (p_rstidle) else $error("not idle after reset");
c_roll: cover property ($rose(o_rollover_flag[1]));
c_gev: cover property ($rose(o_gate_event_flag[0]));
c_bad: cover property (o_s_axi_rvalid && o_s_axi_rresp == 2'h2);
endmodule // gated_timer_sva

// *** dv/gate_src_model.sv ***
`timescale 1ns/10ps
// ==========================================
// gate sources (gate pins and on-chip signals) and count ticks
module gate_src_model (
    input  wire       i_tick_en,
    input  wire [5:0] i_lvl,
    output wire [2:0] o_gate_pin,
    output wire       o_timer0_ovf,
    output wire       o_cmp1_out,
    output wire       o_cmp2_out,
    output wire [2:0] o_count_tick
);
// each source on its own line so a wrong select shows
assign o_gate_pin   = i_lvl[2:0];
assign o_timer0_ovf = i_lvl[3];
assign o_cmp1_out   = i_lvl[4];
assign o_cmp2_out   = i_lvl[5];
assign o_count_tick = {3{i_tick_en}};
endmodule // gate_src_model

// *** dv/tb.sv ***
`timescale 1ns/10ps
`include "gated_timer_consts.vh"
// ==========================================
// bench
module tb;
reg        i_mclk = 1'b0;
reg        rst_b = 1'b0;
reg  [7:0] awaddr = 8'h00;
reg  [7:0] araddr = 8'h00;
reg [31:0] wdata = 32'h0;
reg        awv = 1'b0;
reg        wv = 1'b0;
reg        bready = 1'b0;
reg        arv = 1'b0;
reg        rready = 1'b0;
reg        tick_en = 1'b0;
reg  [5:0] lvl = 6'h00;
reg  [7:0] rd_data;
reg  [1:0] rsp;
integer    n_mismatch = 0;
integer    n_compared = 0;
integer    cyc = 0;
integer    k;
wire        awready, wready, bvalid, arready, rvalid;
wire  [1:0] bresp, rresp;
wire [31:0] rdata;
wire  [2:0] pin, tick, roll, gev;
wire        ovf, cmp1, cmp2;
always #4 i_mclk = ~i_mclk;
gate_src_model u_gate_src_model (.i_tick_en(tick_en), .i_lvl(lvl), .o_gate_pin(pin),
    .o_timer0_ovf(ovf), .o_cmp1_out(cmp1), .o_cmp2_out(cmp2), .o_count_tick(tick));
gated_timer_top u_gated_timer_top (.i_mclk(i_mclk), .i_rst_b(rst_b),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_gate_pin(pin),
    .i_cmp1_out(cmp1), .i_cmp2_out(cmp2), .i_timer0_ovf(ovf), .i_count_tick(tick),
    .o_rollover_flag(roll), .o_gate_event_flag(gev));
function [7:0] ad(input [1:0] t, input [2:0] r);
    ad = {1'b0, t, r, 2'b00};
endfunction
task test_done;
    if (n_mismatch == 0 && n_compared > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task check(input [31:0] s, input [31:0] e);
    n_compared = n_compared + 1;
    if (s !== e) begin
        $display("ERROR %0t seen %h exp %h", $time, s, e);
        n_mismatch = n_mismatch + 1;
    end
endtask
// ready rises with the request and drops once the answer is taken
task wr(input [7:0] a, input [7:0] d);
    reg ta, tw, hs;
    @(posedge i_mclk);
    awaddr <= a; wdata <= {24'h0, d}; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    do begin
        @(negedge i_mclk);
        ta = awv && awready; tw = wv && wready; hs = bvalid && bready; rsp = bresp;
        @(posedge i_mclk);
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
    end while (!hs);
    bready <= 1'b0;
endtask
task rd(input [7:0] a);
    reg ta, hs;
    @(posedge i_mclk);
    araddr <= a; arv <= 1'b1; rready <= 1'b1;
    do begin
        @(negedge i_mclk);
        ta = arv && arready; hs = rvalid && rready;
        rd_data = rdata[7:0]; rsp = rresp;
        @(posedge i_mclk);
        if (ta) arv <= 1'b0;
    end while (!hs);
    rready <= 1'b0;
endtask
task settle;
    repeat (12) @(posedge i_mclk);
endtask
task ticks(input integer n);
    @(posedge i_mclk);
    tick_en <= 1'b1;
    repeat (n) @(posedge i_mclk);
    tick_en <= 1'b0;
endtask
task t_reset;
    for (k = 0; k < 3; k = k + 1) begin
        // low pin under active-low polarity reads as an open gate
        rd(ad(k, `REG_GATE_CTRL)); check(rd_data, 8'h04);
    end
endtask
task t_count;
    wr(ad(1, `REG_COUNT_LOW), 8'h5a); wr(ad(1, `REG_COUNT_HIGH), 8'ha5);
    ticks(5);
    rd(ad(1, `REG_COUNT_LOW)); check(rd_data, 8'h5a);
    rd(ad(1, `REG_COUNT_HIGH)); check(rd_data, 8'ha5);
    wr(ad(1, `REG_TIMER_CTRL), 8'h01);
    ticks(10);
    rd(ad(1, `REG_COUNT_LOW)); check(rd_data, 8'h64);
    wr(ad(1, `REG_COUNT_LOW), 8'hff); wr(ad(1, `REG_COUNT_HIGH), 8'hff);
    ticks(1);
    repeat (3) @(posedge i_mclk);
    check(roll[1], 1'b1);
    rd(ad(1, `REG_COUNT_HIGH)); check(rd_data, 8'h00);
    wr(ad(1, `REG_FLAGS), 8'h01); wr(ad(1, `REG_TIMER_CTRL), 8'h00);
    check(roll[1], 1'b0);
endtask
task t_gate;
    wr(ad(0, `REG_GATE_CTRL), 8'hc0); wr(ad(0, `REG_TIMER_CTRL), 8'h01);
    settle; ticks(6);
    rd(ad(0, `REG_COUNT_LOW)); check(rd_data, 8'h00);
    lvl <= 6'h01; settle; ticks(6);
    rd(ad(0, `REG_COUNT_LOW)); check(rd_data, 8'h06);
    rd(ad(0, `REG_GATE_CTRL)); check(rd_data, 8'hc4);
    // clear first so the next fall is the one that sets the flag
    wr(ad(0, `REG_FLAGS), 8'h02); check(gev[0], 1'b0);
    wr(ad(0, `REG_GATE_CTRL), 8'h80); settle; ticks(6);
    rd(ad(0, `REG_COUNT_LOW)); check(rd_data, 8'h06);
    check(gev[0], 1'b1);
    lvl <= 6'h00; settle; ticks(3);
    rd(ad(0, `REG_COUNT_LOW)); check(rd_data, 8'h09);
endtask
task t_src;
    for (k = 0; k < 4; k = k + 1) begin
        wr(ad(2, `REG_GATE_CTRL), 8'h40 | k);
        lvl <= 6'h04 << k; settle;
        rd(ad(2, `REG_GATE_CTRL)); check(rd_data, 8'h44 | k);
        lvl <= ~(6'h04 << k); settle;
        rd(ad(2, `REG_GATE_CTRL)); check(rd_data, 8'h40 | k);
    end
    lvl <= 6'h00;
endtask
task t_toggle;
    wr(ad(0, `REG_GATE_CTRL), 8'h60); settle;
    rd(ad(0, `REG_GATE_CTRL)); check(rd_data, 8'h60);
    lvl <= 6'h01; settle;
    rd(ad(0, `REG_GATE_CTRL)); check(rd_data, 8'h64);
    lvl <= 6'h00; settle;
    rd(ad(0, `REG_GATE_CTRL)); check(rd_data, 8'h64);
    lvl <= 6'h01; settle;
    rd(ad(0, `REG_GATE_CTRL)); check(rd_data, 8'h60);
    lvl <= 6'h00;
endtask
task t_pulse;
    wr(ad(0, `REG_COUNT_LOW), 8'h00);
    wr(ad(0, `REG_GATE_CTRL), 8'hd8); settle; ticks(4);
    rd(ad(0, `REG_GATE_CTRL)); check(rd_data, 8'hd8);
    lvl <= 6'h01; settle; ticks(5);
    lvl <= 6'h00; settle;
    rd(ad(0, `REG_GATE_CTRL)); check(rd_data, 8'hd0);
    lvl <= 6'h01; settle; ticks(3);
    rd(ad(0, `REG_COUNT_LOW)); check(rd_data, 8'h05);
    lvl <= 6'h00;
    // toggle plus single pulse: counts through the low half as well
    wr(ad(0, `REG_COUNT_LOW), 8'h00); wr(ad(0, `REG_GATE_CTRL), 8'hf8);
    lvl <= 6'h01; settle; ticks(2);
    lvl <= 6'h00; settle; ticks(3);
    lvl <= 6'h01; settle; ticks(2);
    rd(ad(0, `REG_COUNT_LOW)); check(rd_data, 8'h05);
    rd(ad(0, `REG_GATE_CTRL)); check(rd_data, 8'hf0);
    lvl <= 6'h00;
    wr(ad(0, `REG_GATE_CTRL), 8'h58);
    rd(ad(0, `REG_GATE_CTRL)); check(rd_data, 8'h58);
    wr(ad(0, `REG_GATE_CTRL), 8'h48);
    rd(ad(0, `REG_GATE_CTRL)); check(rd_data, 8'h40);
endtask
task t_bad;
    rd(8'h60); check(rsp, `RESP_SLVERR);
    rd(ad(0, 3'h5)); check(rsp, `RESP_SLVERR);
    wr(8'h74, 8'h01); check(rsp, `RESP_SLVERR);
    rd(ad(0, `REG_COUNT_LOW)); check(rsp, `RESP_OKAY);
endtask
always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        n_mismatch = n_mismatch + 1;
        test_done;
    end
end
initial begin
    repeat (12) @(posedge i_mclk);
    rst_b <= 1'b1;
    t_reset; t_count; t_gate; t_src; t_toggle; t_pulse; t_bad;
    test_done;
end
endmodule // tb
bind gated_timer_top gated_timer_sva #(.ADDR_W(ADDR_W), .N_TMR(N_TMR)) u_gated_timer_sva (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .o_s_axi_awready(o_s_axi_awready),
    .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp),
    .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
    .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
    .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
    .i_count_tick(i_count_tick), .o_rollover_flag(o_rollover_flag),
    .o_gate_event_flag(o_gate_event_flag));
